// file: rtl/urbg_channel.sv
// Purpose: one serial channel: ready/interrupt levels, baud gen, transmitter
// Assumes: bus strobes one cycle, read data valid the cycle after the strobe
// Notes:   receive fifo is filled from a simple byte-push port
// Overview of operation
// - no fifo: tx irq high when holding empty
// - fifo: tx irq low above trigger
// - no fifo: rx irq high with byte
// - fifo: rx irq above trigger
// - block bit only steers ready outputs
// - no fifo: rx ready low with byte
// - fifo single mode: rx ready low nonempty
// - block mode: rx ready latches until empty
// - no fifo: tx ready low when empty
// - fifo single mode: tx ready low empty
// - block mode: tx ready low if space
// - fifo bit enables both fifos
// - modem bit 7 selects prescale four
// - divisor 1..65535 gives 16x tick
// - sixteen ticks per serial bit
// - start, data, parity, stop framing
// - 8-bit shifter and 64-byte fifo
// - status bits 5 and 6 report
// - bus runs on system clock only
// - shifter empty needs fifo empty too
// - timeout four chars plus twelve bits
module urbg_channel
  import urbg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // register bus
  input  wire urbg_bus_t  bus_i,
  output logic [7:0]      rdata_o,
  // trigger levels
  input  wire urbg_trig_t trig_i,
  // receive byte push
  input  wire logic       rx_push_i,
  input  wire logic [7:0] rx_byte_i,
  // serial and status pins
  output logic            txd_o,
  output logic            tx_int_o,
  output logic            rx_int_o,
  output logic            rx_ready_n_out_o,
  output logic            tx_ready_n_out_o,
  output logic            tick16_o
);

  logic [7:0]            fifo_control_reg_ff;
  logic [7:0]            modem_control_reg_ff;
  logic [7:0]            line_ctl_ff;
  logic [7:0]            divisor_low_byte_ff;
  logic [7:0]            divisor_high_byte_ff;
  logic [7:0]            rdata_ff;
  logic [7:0]            tx_mem [URBG_DEPTH];
  logic [7:0]            rx_mem [URBG_DEPTH];
  logic [URBG_PTR_W-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic [URBG_CNT_W-1:0] tx_cnt_ff, rx_cnt_ff;
  logic [1:0]            pre_ff;
  logic [15:0]           brg_ff;
  logic                  tick_ff;
  urbg_txst_t            st_ff;
  logic [3:0]            sub_ff;
  logic [2:0]            bit_ff;
  logic [7:0]            tx_shifter_ff;
  logic                  par_ff;
  logic                  stop2_ff;
  logic                  txd_ff;
  logic [9:0]            to_ff;
  logic                  to_hit_ff;
  logic                  rx_blk_n_ff;

  logic fifo_on, blk_on, wr_hit, rd_hit, tx_push, tx_pop, rx_pop;
  logic tx_full, tx_empty, rx_full, rx_empty, sh_idle;
  logic [7:0] lsr_val;
  logic [9:0] to_limit;

  function automatic logic hit(input urbg_bus_t b, input logic [2:0] a);
    return b.addr == a;
  endfunction

  assign fifo_on = fifo_control_reg_ff[URBG_FC_EN];
  // block bit only for ready pins
  assign blk_on  = fifo_on & fifo_control_reg_ff[URBG_FC_BLK];
  assign wr_hit  = bus_i.wr;
  assign rd_hit  = bus_i.rd;
  assign tx_full  = tx_cnt_ff == URBG_CNT_W'(URBG_DEPTH);
  assign tx_empty = tx_cnt_ff == '0;
  assign rx_full  = fifo_on ? (rx_cnt_ff == URBG_CNT_W'(URBG_DEPTH))
                            : (rx_cnt_ff != '0);
  assign rx_empty = rx_cnt_ff == '0;
  // non-fifo mode holds a single byte
  assign tx_push = wr_hit & hit(bus_i, URBG_REG_DATA) &
                   (fifo_on ? !tx_full : tx_empty);
  assign rx_pop  = rd_hit & hit(bus_i, URBG_REG_DATA) & !rx_empty;
  assign tx_pop  = tick_ff & (st_ff == URBG_TX_IDLE) & !tx_empty;
  assign sh_idle = st_ff == URBG_TX_IDLE;

  // configuration registers
  // bus uses system clock, not baud tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fifo_control_reg_ff  <= URBG_FC_RST;
      modem_control_reg_ff <= URBG_MC_RST;
      line_ctl_ff          <= URBG_LC_RST;
      divisor_low_byte_ff  <= URBG_DIV_RST[7:0];
      divisor_high_byte_ff <= URBG_DIV_RST[15:8];
    end else if (wr_hit) begin
      if (hit(bus_i, URBG_REG_FIFOCTL))
        fifo_control_reg_ff <= bus_i.wdata;
      if (hit(bus_i, URBG_REG_MODEM))
        modem_control_reg_ff <= bus_i.wdata;
      if (hit(bus_i, URBG_REG_LINECTL))
        line_ctl_ff <= bus_i.wdata;
      if (hit(bus_i, URBG_REG_DIVLO))
        divisor_low_byte_ff <= bus_i.wdata;
      if (hit(bus_i, URBG_REG_DIVHI))
        divisor_high_byte_ff <= bus_i.wdata;
    end
  end

  always_comb begin
    lsr_val = 8'h00;
    lsr_val[URBG_LS_RX_READY_N_OUT]   = !rx_empty;
    lsr_val[URBG_LS_TXEMPTY] = tx_empty;
    lsr_val[URBG_LS_SHEMPTY] = tx_empty & sh_idle;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_hit) begin
      unique case (bus_i.addr)
        URBG_REG_DATA:    rdata_ff <= rx_mem[rx_rp_ff];
        URBG_REG_DIVLO:   rdata_ff <= divisor_low_byte_ff;
        URBG_REG_FIFOCTL: rdata_ff <= fifo_control_reg_ff;
        URBG_REG_LINECTL: rdata_ff <= line_ctl_ff;
        URBG_REG_MODEM:   rdata_ff <= modem_control_reg_ff;
        URBG_REG_LSTAT:   rdata_ff <= lsr_val;
        URBG_REG_DIVHI:   rdata_ff <= divisor_high_byte_ff;
        URBG_REG_TRIG:    rdata_ff <= {1'b0, tx_cnt_ff};
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign rdata_o = rdata_ff;

  // transmit fifo
  // 64-byte fifo, head is holding reg
  always_ff @(posedge clk_i) begin
    if (tx_push)
      tx_mem[tx_wp_ff] <= bus_i.wdata;
    if (rx_push_i && !rx_full)
      rx_mem[rx_wp_ff] <= rx_byte_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_wp_ff  <= '0;
      tx_rp_ff  <= '0;
      tx_cnt_ff <= '0;
    end else begin
      if (tx_push)
        tx_wp_ff <= tx_wp_ff + 1'b1;
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + 1'b1;
      tx_cnt_ff <= tx_cnt_ff + URBG_CNT_W'(tx_push) - URBG_CNT_W'(tx_pop);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_wp_ff  <= '0;
      rx_rp_ff  <= '0;
      rx_cnt_ff <= '0;
    end else begin
      if (rx_push_i && !rx_full)
        rx_wp_ff <= rx_wp_ff + 1'b1;
      if (rx_pop)
        rx_rp_ff <= rx_rp_ff + 1'b1;
      rx_cnt_ff <= rx_cnt_ff + URBG_CNT_W'(rx_push_i && !rx_full)
                 - URBG_CNT_W'(rx_pop);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_ff  <= '0;
      brg_ff  <= 16'h0001;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (!modem_control_reg_ff[URBG_MC_PRE] ||
          pre_ff == 2'(URBG_PRE_DIV4 - 1)) begin
        pre_ff <= '0;
        if (brg_ff <= 16'h0001) begin
          brg_ff  <= {divisor_high_byte_ff, divisor_low_byte_ff};
          tick_ff <= 1'b1;
        end else begin
          brg_ff <= brg_ff - 1'b1;
        end
      end else begin
        pre_ff <= pre_ff + 1'b1;
      end
    end
  end
  assign tick16_o = tick_ff;

  // transmitter
  // frame sequence
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff         <= URBG_TX_IDLE;
      sub_ff        <= '0;
      bit_ff        <= '0;
      tx_shifter_ff <= '0;
      par_ff        <= 1'b0;
      stop2_ff      <= 1'b0;
      txd_ff        <= 1'b1;
    end else if (tick_ff) begin
      sub_ff <= (st_ff == URBG_TX_IDLE) ? 4'h0 : sub_ff + 1'b1;
      unique case (st_ff)
        URBG_TX_IDLE: begin
          txd_ff <= 1'b1;
          if (!tx_empty) begin
            tx_shifter_ff <= tx_mem[tx_rp_ff];
            par_ff        <= ^(tx_mem[tx_rp_ff] &
                               (8'hff >> (2'd3 - line_ctl_ff[1:0]))) ^
                             ~line_ctl_ff[4];
            stop2_ff      <= line_ctl_ff[2];
            bit_ff        <= '0;
            txd_ff        <= 1'b0;
            st_ff         <= URBG_TX_START;
          end
        end
        URBG_TX_START: begin
          if (sub_ff == 4'(URBG_MID_TICK)) begin
            txd_ff <= tx_shifter_ff[0];
            st_ff  <= URBG_TX_DATA;
          end
        end
        URBG_TX_DATA: begin
          if (sub_ff == 4'(URBG_MID_TICK)) begin
            tx_shifter_ff <= {1'b0, tx_shifter_ff[7:1]};
            bit_ff        <= bit_ff + 1'b1;
            if (bit_ff == {1'b1, line_ctl_ff[1:0]}) begin
              txd_ff <= line_ctl_ff[3] ? par_ff : 1'b1;
              st_ff  <= line_ctl_ff[3] ? URBG_TX_PAR : URBG_TX_STOP;
            end else begin
              txd_ff <= tx_shifter_ff[1];
            end
          end
        end
        URBG_TX_PAR: begin
          if (sub_ff == 4'(URBG_MID_TICK)) begin
            txd_ff <= 1'b1;
            st_ff  <= URBG_TX_STOP;
          end
        end
        URBG_TX_STOP: begin
          if (sub_ff == 4'(URBG_MID_TICK)) begin
            if (stop2_ff)
              stop2_ff <= 1'b0;
            else
              st_ff <= URBG_TX_IDLE;
          end
        end
      endcase
    end
  end
  assign txd_o = txd_ff;

  assign to_limit = 10'((URBG_TO_CHARS * (line_ctl_ff[1:0] + 5)
                   + URBG_TO_EXTRA) * URBG_BIT_TICKS);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      to_ff     <= '0;
      to_hit_ff <= 1'b0;
    end else if (rx_push_i || rx_pop || rx_empty) begin
      to_ff     <= '0;
      to_hit_ff <= 1'b0;
    end else if (tick_ff && to_ff != to_limit) begin
      to_ff <= to_ff + 1'b1;
      to_hit_ff <= (to_ff + 1'b1) == to_limit;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rx_blk_n_ff <= 1'b1;
    else if (rx_empty)
      rx_blk_n_ff <= 1'b1;
    else if (rx_cnt_ff >= trig_i.rx_trig || to_hit_ff)
      rx_blk_n_ff <= 1'b0;
  end

  always_comb begin
    tx_int_o = fifo_on ? !(tx_cnt_ff > trig_i.tx_trig) : tx_empty;
    rx_int_o = fifo_on ? (rx_cnt_ff > trig_i.rx_trig) : !rx_empty;
    if (!fifo_on) begin
      rx_ready_n_out_o = rx_empty;
      tx_ready_n_out_o = !tx_empty;
    end else if (!blk_on) begin
      rx_ready_n_out_o = rx_empty;
      tx_ready_n_out_o = !tx_empty;
    end else begin
      rx_ready_n_out_o = rx_blk_n_ff;
      tx_ready_n_out_o = tx_full;
    end
  end

endmodule // urbg_channel

// file: rtl/urbg_pkg.sv
// Purpose: shared constants and types for the channel ready/baud/tx block
// Assumes: single 200 MHz clock domain
// Notes:   fifo depth and field positions fixed
package urbg_pkg;
  localparam int unsigned URBG_DEPTH      = 64;
  localparam int unsigned URBG_PTR_W      = 6;
  localparam int unsigned URBG_CNT_W      = 7;
  localparam int unsigned URBG_BIT_TICKS  = 16;
  localparam int unsigned URBG_MID_TICK   = 15;
  localparam int unsigned URBG_PRE_DIV4   = 4;
  localparam int unsigned URBG_TO_CHARS   = 4;
  localparam int unsigned URBG_TO_EXTRA   = 12;
  // register indices (byte address = index)
  localparam logic [2:0] URBG_REG_DATA    = 3'h0;
  localparam logic [2:0] URBG_REG_DIVLO   = 3'h1;
  localparam logic [2:0] URBG_REG_FIFOCTL = 3'h2;
  localparam logic [2:0] URBG_REG_LINECTL = 3'h3;
  localparam logic [2:0] URBG_REG_MODEM   = 3'h4;
  localparam logic [2:0] URBG_REG_LSTAT   = 3'h5;
  localparam logic [2:0] URBG_REG_DIVHI   = 3'h6;
  localparam logic [2:0] URBG_REG_TRIG    = 3'h7;
  // field positions
  localparam int unsigned URBG_FC_EN      = 0;
  localparam int unsigned URBG_FC_BLK     = 3;
  localparam int unsigned URBG_MC_PRE     = 7;
  localparam int unsigned URBG_LS_RX_READY_N_OUT   = 0;
  localparam int unsigned URBG_LS_TXEMPTY = 5;
  localparam int unsigned URBG_LS_SHEMPTY = 6;
  // reset values
  localparam logic [7:0] URBG_FC_RST      = 8'h00;
  localparam logic [7:0] URBG_MC_RST      = 8'h00;
  localparam logic [7:0] URBG_LC_RST      = 8'h03;
  localparam logic [15:0] URBG_DIV_RST    = 16'h0001;

  typedef enum logic [4:0] {
    URBG_TX_IDLE  = 5'b00001,
    URBG_TX_START = 5'b00010,
    URBG_TX_DATA  = 5'b00100,
    URBG_TX_PAR   = 5'b01000,
    URBG_TX_STOP  = 5'b10000
  } urbg_txst_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } urbg_bus_t;

  typedef struct packed {
    logic [URBG_CNT_W-1:0] rx_trig;
    logic [URBG_CNT_W-1:0] tx_trig;
  } urbg_trig_t;
endpackage

// file: tb/urbg_channel_sva.sv
// Purpose: port checks for one serial channel
// Assumes: mode and divisor are copied from bus writes
// Notes:   trigger inputs stay below the fifo depth
module urbg_channel_sva
  import urbg_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // register bus and levels
  input wire urbg_bus_t  bus_i,
  input wire logic [7:0] rdata_o,
  input wire urbg_trig_t trig_i,
  // status outputs
  input wire logic       tx_int_o,
  input wire logic       rx_int_o,
  input wire logic       rx_ready_n_out_o,
  input wire logic       tx_ready_n_out_o,
  input wire logic       tick16_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  fc_ff;
  logic        cfg_q_ff;
  logic        pre_ff;
  logic        armed_ff;
  logic [15:0] div_ff;
  logic [19:0] gap_ff;
  logic [19:0] per;
  logic        cfg_wr;
  logic        fen;
  logic        blk;

  assign fen    = fc_ff[URBG_FC_EN];
  assign blk    = fc_ff[URBG_FC_BLK];
  assign cfg_wr = bus_i.wr && (bus_i.addr inside
                  {URBG_REG_DIVLO, URBG_REG_DIVHI, URBG_REG_MODEM});
  assign per    = (pre_ff ? 20'h00004 : 20'h00001) *
                  ((div_ff == 16'h0000) ? 20'h00001 : {4'h0, div_ff});

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fc_ff  <= URBG_FC_RST;
      pre_ff <= 1'b0;
      div_ff <= URBG_DIV_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == URBG_REG_FIFOCTL) fc_ff <= bus_i.wdata;
      if (bus_i.addr == URBG_REG_MODEM) pre_ff <= bus_i.wdata[URBG_MC_PRE];
      if (bus_i.addr == URBG_REG_DIVLO) div_ff[7:0] <= bus_i.wdata;
      if (bus_i.addr == URBG_REG_DIVHI) div_ff[15:8] <= bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_ff   <= 20'h00001;
      armed_ff <= 1'b0;
      cfg_q_ff <= 1'b0;
    end else begin
      gap_ff   <= tick16_o ? 20'h00001 : gap_ff + 20'h00001;
      // reload on the edge after a write still uses the old setting
      cfg_q_ff <= cfg_wr;
      armed_ff <= !cfg_wr && !cfg_q_ff && (armed_ff || tick16_o);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  rdata_idle_a: assert property (
    !$past(bus_i.rd) |-> rdata_o == 8'h00) else $error("read data not idle");
  tx_hold_a: assert property (
    !fen |-> tx_ready_n_out_o == !tx_int_o) else $error("tx holder levels");
  rx_hold_a: assert property (
    !fen |-> rx_ready_n_out_o == !rx_int_o) else $error("rx holder levels");
  tx_single_a: assert property (
    fen && !blk && !tx_ready_n_out_o |-> tx_int_o) else $error("tx empty irq");
  rx_single_a: assert property (
    fen && !blk && rx_int_o |-> !rx_ready_n_out_o) else $error("rx ready");
  rx_block_a: assert property (
    fen && blk && rx_int_o |-> !rx_ready_n_out_o) else $error("rx block");
  rx_release_a: assert property (
    fen && blk && $rose(rx_ready_n_out_o) |-> !rx_int_o)
    else $error("rx ready released early");
  tx_full_a: assert property (
    fen && blk && tx_ready_n_out_o && trig_i.tx_trig < 7'd64 |-> !tx_int_o)
    else $error("tx full irq");
  tick_period_a: assert property (
    tick16_o && armed_ff |-> gap_ff == per) else $error("tick period");
endmodule // urbg_channel_sva

bind urbg_channel urbg_channel_sva u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .trig_i(trig_i), .tx_int_o(tx_int_o), .rx_int_o(rx_int_o),
  .rx_ready_n_out_o(rx_ready_n_out_o), .tx_ready_n_out_o(tx_ready_n_out_o),
  .tick16_o(tick16_o)
);

// file: tb/urbg_line_model.sv
// Purpose: remote receiver decoding the serial output
// Assumes: 8 data bits, no parity, one stop bit
// Notes:   samples mid-bit by counting 16x ticks
module urbg_line_model (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  // serial line and tick
  input  wire logic  txd_i,
  input  wire logic  tick_i,
  // decoded character
  output logic [7:0] byte_o,
  output logic       got_o,
  output logic       bad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_ff;
  logic [7:0] tcnt_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_ff <= 1'b0;
      tcnt_ff <= 8'h00;
      byte_o  <= 8'h00;
      got_o   <= 1'b0;
      bad_o   <= 1'b0;
    end else begin
      got_o <= 1'b0;
      if (!busy_ff) begin
        busy_ff <= !txd_i;
        tcnt_ff <= 8'h00;
      end else if (tick_i) begin
        tcnt_ff <= tcnt_ff + 8'h01;
        if (tcnt_ff[3:0] == 4'h7) begin
          if (tcnt_ff[7:4] == 4'h0) begin
            busy_ff <= !txd_i;
          end else if (tcnt_ff[7:4] == 4'h9) begin
            busy_ff <= 1'b0;
            got_o   <= 1'b1;
            bad_o   <= !txd_i;
          end else begin
            byte_o <= {txd_i, byte_o[7:1]};
          end
        end
      end
    end
  end
endmodule // urbg_line_model

// file: tb/urbg_channel_tb.sv
// Purpose: self-checking bench for one serial channel
// Assumes: 8N1 framing after reset
// Notes:   each row restarts the channel from reset
module urbg_channel_tb
  import urbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] fc;
    logic [6:0] nw;
    logic [6:0] np;
    logic [6:0] trg;
    logic [3:0] lvl;
    logic [6:0] txc;
  } urbg_row_t;
  // lvl: tx irq, rx irq, rx ready_n, tx ready_n
  urbg_row_t  rows [7] = '{
    '{8'h00, 7'd0, 7'd0, 7'd8, 4'b1010, 7'd0},
    '{8'h00, 7'd3, 7'd2, 7'd8, 4'b0101, 7'd1},
    '{8'h01, 7'd1, 7'd1, 7'd8, 4'b1000, 7'd0},
    '{8'h01, 7'd10, 7'd9, 7'd8, 4'b0101, 7'd9},
    '{8'h09, 7'd9, 7'd8, 7'd8, 4'b1000, 7'd8},
    '{8'h09, 7'd65, 7'd7, 7'd8, 4'b0011, 7'd64},
    '{8'h09, 7'd2, 7'd64, 7'd8, 4'b1100, 7'd1}};
  logic [7:0] exp_b [3] = '{8'ha5, 8'h3c, 8'h95};
  logic       clk_i = 1'b0;
  logic       rstn_q;
  urbg_bus_t  bus_q;
  urbg_trig_t trig_q;
  logic       rx_push_q;
  logic [7:0] rx_byte_q, rdata, v, rx_b;
  logic       txd, tx_int, rx_int, rx_rdy_n, tx_rdy_n, tick, got, bad;
  int         n_fail = 0, checks = 0, n;

  always #2.5 clk_i = ~clk_i;

  urbg_channel DUT (.clk_i(clk_i), .rstn_i(rstn_q), .bus_i(bus_q),
    .rdata_o(rdata), .trig_i(trig_q), .rx_push_i(rx_push_q),
    .rx_byte_i(rx_byte_q), .txd_o(txd), .tx_int_o(tx_int),
    .rx_int_o(rx_int), .rx_ready_n_out_o(rx_rdy_n),
    .tx_ready_n_out_o(tx_rdy_n), .tick16_o(tick));
  urbg_line_model u_line (.clk_i(clk_i), .rstn_i(rstn_q), .txd_i(txd),
    .tick_i(tick), .byte_o(rx_b), .got_o(got), .bad_o(bad));

  task automatic wrap_up;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_q <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_q <= '0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    bus_q <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_q <= '0;
    #1;
    v = rdata;
  endtask
  task automatic push(input int m);
    for (int i = 0; i < m; i++) begin
      @(posedge clk_i);
      rx_push_q <= 1'b1;
      rx_byte_q <= 8'(i);
    end
    @(posedge clk_i);
    rx_push_q <= 1'b0;
  endtask
  task automatic rst;
    @(posedge clk_i);
    rstn_q <= 1'b0;
    @(posedge clk_i);
    rstn_q <= 1'b1;
  endtask

  initial begin
    #100us;
    $display("[FAIL] %0t watchdog expired", $time);
    n_fail++;
    wrap_up();
  end

  initial begin
    {rstn_q, bus_q, rx_push_q, rx_byte_q} = '0;
    trig_q = '{7'd8, 7'd8};
    repeat (16) @(posedge clk_i);
    rstn_q <= 1'b1;
    foreach (rows[i]) begin
      trig_q <= '{rows[i].trg, rows[i].trg};
      rst();
      wr(URBG_REG_DIVLO, 8'h04);
      wr(URBG_REG_FIFOCTL, rows[i].fc);
      for (int k = 0; k < rows[i].nw; k++) wr(URBG_REG_DATA, 8'(k));
      push(rows[i].np);
      repeat (8) @(posedge clk_i);
      #1;
      v = {4'h0, tx_int, rx_int, rx_rdy_n, tx_rdy_n};
      chk(v, {4'h0, rows[i].lvl});
      wr(URBG_REG_TRIG, 8'h3f);
      rd(URBG_REG_TRIG);
      chk(v, {1'b0, rows[i].txc});
      rd(URBG_REG_LSTAT);
      chk(v & 8'h61, {1'b0, rows[i].nw == 0, rows[i].txc == 0, 4'h0,
          rows[i].np != 0});
    end
    // block mode: ready holds until empty
    trig_q <= '{7'd2, 7'd2};
    rst();
    wr(URBG_REG_FIFOCTL, 8'h09);
    push(2);
    rd(URBG_REG_DATA);
    chk(v, 8'h00);
    chk({7'h0, rx_rdy_n}, 8'h00);
    rd(URBG_REG_DATA);
    chk(v, 8'h01);
    // latch releases one edge after the fifo empties
    @(posedge clk_i);
    #1;
    chk({7'h0, rx_rdy_n}, 8'h01);
    // block mode: timeout after 44 bit times
    trig_q <= '{7'd8, 7'd8};
    rst();
    wr(URBG_REG_FIFOCTL, 8'h09);
    push(1);
    repeat (690) @(posedge clk_i);
    #1;
    chk({7'h0, rx_rdy_n}, 8'h01);
    repeat (40) @(posedge clk_i);
    #1;
    chk({7'h0, rx_rdy_n}, 8'h00);
    // framing at divisor 3 with prescale 4
    rst();
    wr(URBG_REG_MODEM, 8'h80);
    wr(URBG_REG_DIVLO, 8'h03);
    wr(URBG_REG_DIVHI, 8'h00);
    wr(URBG_REG_DATA, exp_b[0]);
    n = 0;
    while (txd === 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (txd === 1'b0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk(n[7:0], 8'hc0);
    wr(URBG_REG_DATA, exp_b[1]);
    foreach (exp_b[j]) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (got !== 1'b1 && n < 4000);
      chk(rx_b, exp_b[j]);
      chk({7'h0, bad}, 8'h00);
      // 7 data bits, even parity, two stops: parity lands in bit 7
      if (j == 1) begin
        wr(URBG_REG_LINECTL, 8'h1e);
        wr(URBG_REG_DATA, exp_b[2]);
      end
    end
    wrap_up();
  end
endmodule // urbg_channel_tb
